// ==== pkg/tpoc_pkg.sv ====
// constants and field layout of the timing pattern output controller
// assumes an apb master with 32-bit data; registers sit at index * 4
package tpoc_pkg;
   // ----------------------------------------------------------------
   // register indices (byte address = index * 4)
   // ----------------------------------------------------------------
   localparam logic [15:0] IDX_MODE     = 16'hffa0;
   localparam logic [15:0] IDX_CTRL     = 16'hffa1;
   localparam logic [15:0] IDX_NDE_HIGH = 16'hffa2;
   localparam logic [15:0] IDX_NDE_LOW  = 16'hffa3;
   localparam logic [15:0] IDX_NDR_HI_P = 16'hffa4;
   localparam logic [15:0] IDX_NDR_LO_P = 16'hffa5;
   localparam logic [15:0] IDX_NDR_HI_A = 16'hffa6;
   localparam logic [15:0] IDX_NDR_LO_A = 16'hffa7;
   localparam logic [15:0] IDX_DIR_A    = 16'hffd1;
   localparam logic [15:0] IDX_OUT_A    = 16'hffd3;
   localparam logic [15:0] IDX_DIR_B    = 16'hffd4;
   localparam logic [15:0] IDX_OUT_B    = 16'hffd6;
   // ----------------------------------------------------------------
   // reset values and fields
   // ----------------------------------------------------------------
   localparam logic [7:0]  MODE_RST     = 8'hf0;
   localparam logic [7:0]  CTRL_RST     = 8'hff;
   localparam logic [7:0]  NDE_RST      = 8'h00;
   localparam logic [15:0] NDR_RST      = 16'h0000;
   localparam logic [7:0]  PORT_RST     = 8'h00;
   localparam logic [7:0]  RSVD_ONES    = 8'hff;
   localparam logic [7:0]  WO_READ      = 8'h00;
   localparam int          SEL_W        = 2;
   localparam int          NGRP         = 4;
   localparam int          PIN_ABSENT_B = 6;
endpackage

// ==== rtl/tpoc_group.sv ====
// one four-bit pattern group: trigger pick and load mask
// assumes compare match inputs are one-cycle pulses of the pclk domain
`timescale 1ns/1ps
module tpoc_group #(
   parameter int CH = 4
) (
   input  wire logic [tpoc_pkg::SEL_W-1:0] sel,
   input  wire logic                       novl,
   input  wire logic [CH-1:0]              cmp_a,
   input  wire logic [CH-1:0]              cmp_b,
   input  wire logic [3:0]                 ndr,
   input  wire logic [3:0]                 nde,
   output logic      [3:0]                 load
);
   import tpoc_pkg::*;

   if (CH != (1 << SEL_W)) begin : g_chk
      $error("tpoc_group: CH must equal the trigger select range");
   end

   logic trig_a;
   logic trig_b;

   always_comb begin
      trig_a = cmp_a[sel];
      trig_b = cmp_b[sel];
      if (novl) begin
         // falls at match a, rises at match b
         load = nde & ((~ndr & {4{trig_a}}) | (ndr & {4{trig_b}}));
      end else begin
         load = nde & {4{trig_a}};
      end
   end
endmodule

// ==== rtl/tpoc_ndr_map.sv ====
// address view of one next data register pair (two groups)
// when split, primary address holds the upper nibble, alternate the lower one; when shared, primary holds both
`timescale 1ns/1ps
module tpoc_ndr_map (
   input  wire logic       shared,
   input  wire logic       hit_pri,
   input  wire logic       hit_alt,
   input  wire logic [7:0] cur,
   output logic            hit,
   output logic      [7:0] rdata,
   output logic      [7:0] wmask
);
   import tpoc_pkg::*;

   always_comb begin
      hit   = hit_pri | hit_alt;
      rdata = RSVD_ONES;
      wmask = 8'h00;
      if (shared) begin
         if (hit_pri) begin
            rdata = cur;
            wmask = 8'hff;
         end
      end else if (hit_pri) begin
         rdata = {cur[7:4], RSVD_ONES[3:0]};
         wmask = 8'hf0;
      end else if (hit_alt) begin
         rdata = {RSVD_ONES[7:4], cur[3:0]};
         wmask = 8'h0f;
      end
   end
endmodule

// ==== rtl/tpoc_top.sv ====
// timing pattern output controller with apb register access
// assumes timer compare matches are pclk pulses; ports a/b pins outside
//
// Design decision made here: the APB slave port.
`timescale 1ns/1ps
module tpoc_top #(
   parameter int ADDR_W = 18
) (
   input  wire logic                 pclk,
   input  wire logic                 presetn,
   input  wire logic                 psel,
   input  wire logic                 penable,
   input  wire logic                 pwrite,
   input  wire logic [ADDR_W-1:0]    paddr,
   input  wire logic [31:0]          pwdata,
   input  wire logic [3:0]           pstrb,
   output logic      [31:0]          prdata,
   output logic                      pready,
   output logic                      pslverr,
   input  wire logic [tpoc_pkg::NGRP-1:0] cmp_a,
   input  wire logic [tpoc_pkg::NGRP-1:0] cmp_b,
   input  wire logic                 hw_standby,
   output logic      [7:0]           port_a_out,
   output logic      [7:0]           port_a_oe,
   output logic      [7:0]           port_b_out,
   output logic      [7:0]           port_b_oe
);
   import tpoc_pkg::*;

   if (ADDR_W < 18) begin : g_chk
      $error("tpoc_top: ADDR_W too small for the register map");
   end

   // ----------------------------------------------------------------
   // state
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [3:0]  novl;
      logic [7:0]  ctrl;
      logic [7:0]  nde_hi;
      logic [7:0]  nde_lo;
      logic [15:0] ndr;
      logic [7:0]  dir_a;
      logic [7:0]  dir_b;
      logic [7:0]  out_a;
      logic [7:0]  out_b;
      logic [31:0] rdata;
   } tpoc_state_type;

   tpoc_state_type st_q;
   tpoc_state_type st_d;

   // ----------------------------------------------------------------
   // decode
   // ----------------------------------------------------------------
   logic [15:0] word;
   logic        acc;
   logic        setup_rd;
   logic        wr;
   logic        shared_lo;
   logic        shared_hi;
   logic        hit_lo;
   logic        hit_hi;
   logic        hit_reg;
   logic        hit_any;
   logic [7:0]  rd_lo;
   logic [7:0]  rd_hi;
   logic [7:0]  wm_lo;
   logic [7:0]  wm_hi;
   logic [15:0] load;
   logic [15:0] nde;
   logic [7:0]  rd_byte;

   assign word     = paddr[17:2];
   assign acc      = psel & penable;
   assign setup_rd = psel & ~penable & ~pwrite;
   assign shared_lo = st_q.ctrl[1:0] == st_q.ctrl[3:2];
   assign shared_hi = st_q.ctrl[5:4] == st_q.ctrl[7:6];
   assign nde      = {st_q.nde_hi, st_q.nde_lo};

   always_comb begin
      hit_reg = 1'b1;
      rd_byte = 8'h00;
      case (word)
         IDX_MODE:     rd_byte = {MODE_RST[7:4], st_q.novl};
         IDX_CTRL:     rd_byte = st_q.ctrl;
         IDX_NDE_HIGH: rd_byte = st_q.nde_hi;
         IDX_NDE_LOW:  rd_byte = st_q.nde_lo;
         IDX_DIR_A:    rd_byte = WO_READ;
         IDX_DIR_B:    rd_byte = WO_READ;
         IDX_OUT_A:    rd_byte = st_q.out_a;
         IDX_OUT_B:    rd_byte = st_q.out_b;
         default: begin
            hit_reg = 1'b0;
            // unmapped words read zero, only next data views read ones
            rd_byte = hit_lo ? rd_lo : (hit_hi ? rd_hi : 8'h00);
         end
      endcase
   end

   assign hit_any = hit_reg | hit_lo | hit_hi;
   assign wr      = acc & pwrite & hit_any & pstrb[0];

   tpoc_ndr_map u_map_lo (
      .shared  (shared_lo),
      .hit_pri (word == IDX_NDR_LO_P),
      .hit_alt (word == IDX_NDR_LO_A),
      .cur     (st_q.ndr[7:0]),
      .hit     (hit_lo),
      .rdata   (rd_lo),
      .wmask   (wm_lo)
   );

   tpoc_ndr_map u_map_hi (
      .shared  (shared_hi),
      .hit_pri (word == IDX_NDR_HI_P),
      .hit_alt (word == IDX_NDR_HI_A),
      .cur     (st_q.ndr[15:8]),
      .hit     (hit_hi),
      .rdata   (rd_hi),
      .wmask   (wm_hi)
   );

   // ----------------------------------------------------------------
   // pattern groups
   // ----------------------------------------------------------------
   for (genvar g = 0; g < NGRP; g++) begin : g_grp
      tpoc_group #(.CH(NGRP)) u_grp (
         .sel   (st_q.ctrl[g*SEL_W +: SEL_W]),
         .novl  (st_q.novl[g]),
         .cmp_a (cmp_a),
         .cmp_b (cmp_b),
         .ndr   (st_q.ndr[g*4 +: 4]),
         .nde   (nde[g*4 +: 4]),
         .load  (load[g*4 +: 4])
      );
   end

   // ----------------------------------------------------------------
   // next state
   // ----------------------------------------------------------------
   always_comb begin
      st_d = st_q;
      if (setup_rd) begin
         st_d.rdata = {24'h000000, rd_byte};
      end
      if (wr) begin
         case (word)
            IDX_MODE:     st_d.novl   = pwdata[3:0];
            IDX_CTRL:     st_d.ctrl   = pwdata[7:0];
            IDX_NDE_HIGH: st_d.nde_hi = pwdata[7:0];
            IDX_NDE_LOW:  st_d.nde_lo = pwdata[7:0];
            IDX_DIR_A:    st_d.dir_a  = pwdata[7:0];
            IDX_DIR_B:    st_d.dir_b  = pwdata[7:0];
            IDX_OUT_A: begin
               st_d.out_a = (st_q.out_a & st_q.nde_lo) |
                            (pwdata[7:0] & ~st_q.nde_lo);
            end
            IDX_OUT_B: begin
               st_d.out_b = (st_q.out_b & st_q.nde_hi) |
                            (pwdata[7:0] & ~st_q.nde_hi);
            end
            default: begin
               st_d.ndr[7:0]  = (st_q.ndr[7:0] & ~wm_lo) |
                                (pwdata[7:0] & wm_lo);
               st_d.ndr[15:8] = (st_q.ndr[15:8] & ~wm_hi) |
                                (pwdata[7:0] & wm_hi);
            end
         endcase
      end
      // compare match transfer; enabled bits never take software data
      st_d.out_a = (st_d.out_a & ~load[7:0]) |
                   (st_q.ndr[7:0] & load[7:0]);
      st_d.out_b = (st_d.out_b & ~load[15:8]) |
                   (st_q.ndr[15:8] & load[15:8]);
      if (hw_standby) begin
         st_d.ndr = NDR_RST;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         st_q.novl   <= MODE_RST[3:0];
         st_q.ctrl   <= CTRL_RST;
         st_q.nde_hi <= NDE_RST;
         st_q.nde_lo <= NDE_RST;
         st_q.ndr    <= NDR_RST;
         st_q.dir_a  <= PORT_RST;
         st_q.dir_b  <= PORT_RST;
         st_q.out_a  <= PORT_RST;
         st_q.out_b  <= PORT_RST;
         st_q.rdata  <= 32'h00000000;
      end else begin
         st_q <= st_d;
      end
   end

   // ----------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------
   logic [7:0] pin_mask_b;

   assign pin_mask_b = ~(8'h01 << PIN_ABSENT_B);
   assign prdata     = st_q.rdata;
   assign pready     = acc;
   assign pslverr    = acc & ~hit_any;
   assign port_a_out = st_q.out_a;
   assign port_a_oe  = st_q.dir_a;
   assign port_b_out = st_q.out_b & pin_mask_b;
   assign port_b_oe  = st_q.dir_b & pin_mask_b;

   // ----------------------------------------------------------------
   // checks
   // ----------------------------------------------------------------
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);

   sequence s_wr_word(logic [15:0] idx);
      psel && penable && pwrite && pstrb[0] && word == idx;
   endsequence

   sequence s_rd_setup(logic [15:0] idx);
      psel && !penable && !pwrite && word == idx;
   endsequence

   a_reset_values: assert property (
      $rose(presetn) |-> st_q.novl == 4'h0 && st_q.ctrl == CTRL_RST)
      else $error("mode or control reset value wrong");

   a_enabled_ro: assert property (
      (s_wr_word(IDX_OUT_A) and (load[7:0] == 8'h00)) |=>
      ((st_q.out_a & st_q.nde_lo) ==
       ($past(st_q.out_a) & $past(st_q.nde_lo))))
      else $error("enabled port a bit changed by software");

   a_transfer_copy: assert property (
      (load != 16'h0000) |=>
      (({st_q.out_b, st_q.out_a} & $past(load)) ==
       ($past(st_q.ndr) & $past(load))))
      else $error("compare match transfer lost data");

   a_plain_kept: assert property (
      !(acc && pwrite) |=>
      (({st_q.out_b, st_q.out_a} & ~$past(nde)) ==
       ($past({st_q.out_b, st_q.out_a}) & ~$past(nde))))
      else $error("plain port bit changed by transfer");

   a_standby_clear: assert property (
      hw_standby |=> st_q.ndr == NDR_RST)
      else $error("next data not cleared in standby");

   a_pin_absent: assert property (
      port_b_oe[PIN_ABSENT_B] == 1'b0 && port_b_out[PIN_ABSENT_B] == 1'b0)
      else $error("absent pattern pin driven");

   a_rsvd_read: assert property (
      (s_rd_setup(IDX_NDR_LO_A) and shared_lo) |=>
      penable && prdata[7:0] == RSVD_ONES)
      else $error("reserved next data address not all ones");

   a_split_low: assert property (
      (s_wr_word(IDX_NDR_LO_A) and !shared_lo and !hw_standby) |=>
      st_q.ndr[3:0] == $past(pwdata[3:0]) &&
      st_q.ndr[15:4] == $past(st_q.ndr[15:4]))
      else $error("split low next data write misplaced");

   a_split_high: assert property (
      (s_wr_word(IDX_NDR_HI_P) and !shared_hi and !hw_standby) |=>
      st_q.ndr[15:12] == $past(pwdata[7:4]) &&
      st_q.ndr[11:0] == $past(st_q.ndr[11:0]))
      else $error("split high next data write misplaced");

   a_overlap_guard: assert property (
      (st_q.novl[0] && (|(load[3:0] & st_q.ndr[3:0]))) |->
      cmp_b[st_q.ctrl[1:0]])
      else $error("non-overlap rise without match b");

   a_overlap_fall: assert property (
      (st_q.novl[0] && (|(load[3:0] & ~st_q.ndr[3:0]))) |->
      cmp_a[st_q.ctrl[1:0]])
      else $error("non-overlap fall without match a");

   a_apb_answer: assert property (
      (psel && !penable) ##1 (psel && penable) |-> pready)
      else $error("access phase not answered at once");
endmodule

// ==== verif/tpoc_timer_model.sv ====
// timer compare match source in front of the pattern controller
// assumes requests are driven just after pclk edges by the bench
`timescale 1ns/1ps
module tpoc_timer_model (
   input  wire logic       pclk,
   input  wire logic       presetn,
   input  wire logic [3:0] req_a,
   input  wire logic [3:0] req_b,
   output logic      [3:0] cmp_a,
   output logic      [3:0] cmp_b
);
   logic [7:0] seen_q;
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seen_q <= 8'h00;
      end else begin
         seen_q <= {req_b, req_a};
      end
   end
   // one match pulse per request rise, however long it is held
   assign cmp_a = req_a & ~seen_q[3:0];
   assign cmp_b = req_b & ~seen_q[7:4];
endmodule

// ==== verif/test_timing_pattern_output_ctrl.sv ====
// self-checking bench for the timing pattern output controller
// assumes tpoc_pkg, tpoc_top and tpoc_timer_model are compiled first
`timescale 1ns/1ps
module test_timing_pattern_output_ctrl;
   import tpoc_pkg::*;
   logic        pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [17:0] paddr = '0;
   logic [31:0] pwdata = '0, prdata;
   logic [3:0]  pstrb = 4'hf, req_a = '0, req_b = '0, cmp_a, cmp_b;
   logic        pready, pslverr, er, hw_standby = 0;
   logic [7:0]  pa_o, pa_e, pb_o, pb_e, rd, v, ea, eb;
   int          err_count = 0, n_compared = 0;
   logic [15:0] ri [12] = '{IDX_MODE, IDX_CTRL, IDX_NDE_HIGH, IDX_NDE_LOW,
      IDX_NDR_HI_P, IDX_NDR_LO_P, IDX_NDR_HI_A, IDX_NDR_LO_A, IDX_DIR_A,
      IDX_OUT_A, IDX_DIR_B, IDX_OUT_B};
   logic [7:0]  re [12] = '{8'hf0, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00,
      8'hff, 8'hff, 8'h00, 8'h00, 8'h00, 8'h00};

   always #4 pclk = ~pclk;

   tpoc_top i_dut (.pclk(pclk), .presetn(presetn), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
      .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .cmp_a(cmp_a), .cmp_b(cmp_b), .hw_standby(hw_standby),
      .port_a_out(pa_o), .port_a_oe(pa_e), .port_b_out(pb_o),
      .port_b_oe(pb_e));
   tpoc_timer_model i_tmr (.pclk(pclk), .presetn(presetn), .req_a(req_a),
      .req_b(req_b), .cmp_a(cmp_a), .cmp_b(cmp_b));

   // ----------------------------------------------------------------
   // access and compare tasks
   // ----------------------------------------------------------------
   task automatic cmp8(input string nm, input logic [7:0] e, g);
      n_compared++;
      if (g !== e) begin
         err_count++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic cmp1(input string nm, input logic e, g);
      cmp8(nm, {7'h00, e}, {7'h00, g});
   endtask
   task automatic apb(input logic w, input logic [15:0] ix,
                      input logic [7:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {ix, 2'b00};
      pwdata <= {24'h000000, d};
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata[7:0];
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge pclk);
   endtask
   task automatic wr(input logic [15:0] ix, input logic [7:0] d);
      apb(1'b1, ix, d);
   endtask
   task automatic chk(input logic [15:0] ix, input logic [7:0] e);
      apb(1'b0, ix, 8'h00);
      cmp8($sformatf("register %h", ix), e, rd);
   endtask
   task automatic fire(input logic [3:0] a, input logic [3:0] b);
      @(posedge pclk);
      req_a <= a;
      req_b <= b;
      @(posedge pclk);
      req_a <= 4'h0;
      req_b <= 4'h0;
      @(posedge pclk);
   endtask
   task automatic report_and_stop;
      $display("compared %0d mismatched %0d", n_compared, err_count);
      if (err_count == 0 && n_compared > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // ----------------------------------------------------------------
   // test sequence
   // ----------------------------------------------------------------
   initial begin
      repeat (2) @(posedge pclk);
      presetn <= 1'b1;
      for (int i = 0; i < 12; i++) chk(ri[i], re[i]);
      cmp8("port a out", 8'h00, pa_o);
      $display("test reset values done");
      apb(1'b0, 16'hffa8, 8'h00);
      cmp1("error flag", 1'b1, er);
      cmp8("unmapped read", 8'h00, rd);
      wr(IDX_DIR_A, 8'hff);
      wr(IDX_DIR_B, 8'hff);
      cmp8("port a oe", 8'hff, pa_e);
      cmp8("port b oe", 8'hbf, pb_e);
      chk(IDX_DIR_A, 8'h00);
      wr(IDX_OUT_A, 8'h30);
      cmp8("port a out", 8'h30, pa_o);
      pstrb <= 4'he;
      wr(IDX_OUT_A, 8'h0f);
      pstrb <= 4'hf;
      chk(IDX_OUT_A, 8'h30);
      $display("test plain port done");
      wr(IDX_NDR_LO_P, 8'ha5);
      chk(IDX_NDR_LO_P, 8'ha5);
      wr(IDX_NDR_LO_A, 8'h00);
      chk(IDX_NDR_LO_A, 8'hff);
      chk(IDX_NDR_LO_P, 8'ha5);
      wr(IDX_NDE_LOW, 8'h0f);
      fire(4'h8, 4'h0);
      cmp8("port a out", 8'h35, pa_o);
      wr(IDX_OUT_A, 8'hc0);
      cmp8("port a out", 8'hc5, pa_o);
      $display("test shared transfer done");
      wr(IDX_CTRL, 8'hf4);
      wr(IDX_NDR_LO_P, 8'h90);
      chk(IDX_NDR_LO_P, 8'h9f);
      wr(IDX_NDR_LO_A, 8'h06);
      chk(IDX_NDR_LO_A, 8'hf6);
      wr(IDX_NDE_LOW, 8'hff);
      fire(4'h1, 4'h0);
      cmp8("port a out", 8'hc6, pa_o);
      fire(4'h2, 4'h0);
      cmp8("port a out", 8'h96, pa_o);
      wr(IDX_CTRL, 8'h74);
      wr(IDX_NDR_HI_P, 8'h5c);
      chk(IDX_NDR_HI_P, 8'h5f);
      wr(IDX_NDR_HI_A, 8'h03);
      chk(IDX_NDR_HI_A, 8'hf3);
      $display("test split trigger done");
      wr(IDX_NDE_HIGH, 8'hff);
      ea = 8'h96;
      eb = 8'h00;
      for (int ch = 0; ch < 4; ch++) begin
         v = 8'(8'h11 * (ch + 1));
         wr(IDX_CTRL, {4{2'(ch)}});
         wr(IDX_NDR_LO_P, v);
         wr(IDX_NDR_HI_P, v);
         fire(4'(1 << ((ch + 1) % 4)), 4'h0);
         cmp8("port a out", ea, pa_o);
         cmp8("port b out", eb, pb_o);
         fire(4'(1 << ch), 4'h0);
         ea = v;
         eb = v & 8'hbf;
         cmp8("port a out", ea, pa_o);
         cmp8("port b out", eb, pb_o);
      end
      $display("test channel select done");
      wr(IDX_MODE, 8'h01);
      chk(IDX_MODE, 8'hf1);
      wr(IDX_NDR_LO_P, 8'h4a);
      fire(4'h8, 4'h0);
      cmp8("port a out", 8'h40, pa_o);
      fire(4'h0, 4'h8);
      cmp8("port a out", 8'h4a, pa_o);
      wr(IDX_OUT_A, 8'h00);
      chk(IDX_OUT_A, 8'h4a);
      $display("test non-overlap done");
      @(posedge pclk);
      hw_standby <= 1'b1;
      @(posedge pclk);
      hw_standby <= 1'b0;
      chk(IDX_NDR_LO_P, 8'h00);
      chk(IDX_NDR_HI_P, 8'h00);
      $display("test standby done");
      report_and_stop();
   end

   // about 270 cycles expected; cut off well beyond
   initial begin
      repeat (5000) @(posedge pclk);
      err_count++;
      report_and_stop();
   end
endmodule
